/* File: verilog/pic_defines.vh */
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// ****************************************
// command codes
// ****************************************
`define PIC_CMD_W           4
`define PIC_CMD_NONE        4'h0
`define PIC_CMD_PRE_ON      4'h1
`define PIC_CMD_PRE_OFF     4'h2
`define PIC_CMD_OUT_SET     4'h3
`define PIC_CMD_OUT_CLR     4'h4
`define PIC_CMD_REV_ON      4'h5
`define PIC_CMD_REV_OFF     4'h6
`define PIC_CMD_ILK_SET     4'h7
`define PIC_CMD_ILK_CLR     4'h8
`define PIC_CMD_POT_TYPE    4'h9

// ****************************************
// selectors and selections
// ****************************************
`define PIC_SEL_W           8
`define PIC_SEL_OUT_A       8'h06
`define PIC_SEL_OUT_B       8'h07
`define PIC_CTL_W           4
`define PIC_CTL_SOFT        4'h1

// ****************************************
// precharge status codes
// ****************************************
`define PIC_PST_W           3
`define PIC_PST_NONE        3'h0
`define PIC_PST_BUSY        3'h1
`define PIC_PST_PASS        3'h2
`define PIC_PST_ABORT       3'h3
`define PIC_PST_ENERGY      3'h4
`define PIC_PST_TIMEOUT     3'h5

// ****************************************
// pot wiring types
// ****************************************
`define PIC_POT_W           2
`define PIC_POT_ONE_WIRE    2'h1
`define PIC_POT_TWO_WIRE    2'h2
`define PIC_POT_THREE_WIRE  2'h3

// ****************************************
// widths and timing
// ****************************************
`define PIC_VOLT_W          12
`define PIC_THR_W           16
`define PIC_THR_ZERO        16'h0000
`define PIC_CLK_HZ          40000000
`define PIC_PRE_LIMIT_MS    1000
`define PIC_TMR_W           26

`endif

/* File: verilog/pic_precharge_interlock.v */
`timescale 1ns/100ps
`include "pic_defines.vh"

// Overview of operation
// - precharge runs until voltage in range, timeout, or energy limit exceeded
// - status code 0 none, 1 in progress, 2 passed
// - abort command drops request, clears precharge fault, status becomes 3
// - resistor energy over limit ends precharge, status becomes 4
// - precharge not done within one second ends it, status becomes 5
// - low-side outputs active low: on pulls pin low, off leaves it open
// - output commands accept selectors 6 and 7 only, else invalid-selector error
// - reverse enable/disable act only when reverse control selection is 1
// - reverse flag reads off until first enable or disable command
// - reverse flag off stops reverse; startup check is requested after that if enabled
// - interlock set/clear act only when interlock control selection is 1
// - interlock on passes throttle value; off blocks it
// - with main contactor enabled, setting interlock requests contactor close
// - with main contactor enabled, clearing interlock requests contactor open
// - interlock flag defaults off until first set or clear
// - pot wiring select: one-wire voltage, two-wire rheostat, three-wire pot
// - each command returns 1 when it takes effect, 0 when not
module pic_precharge_interlock #(
  parameter PRE_TIMEOUT_CYC = (`PIC_CLK_HZ / 1000) * `PIC_PRE_LIMIT_MS
) (
  input  wire                      MCLK_I,
  input  wire                      RST_N_I,
  input  wire                      CMD_VALID_I,
  input  wire [`PIC_CMD_W-1:0]     CMD_CODE_I,
  input  wire [`PIC_SEL_W-1:0]     CMD_ARG_I,
  input  wire [`PIC_CTL_W-1:0]     REVERSE_CONTROL_SELECT_I,
  input  wire [`PIC_CTL_W-1:0]     INTERLOCK_CONTROL_SELECT_I,
  input  wire                      MAIN_CONTACTOR_ENABLE_I,
  input  wire                      STARTUP_SEQUENCE_CHECK_EN_I,
  input  wire                      STARTUP_CHECK_DONE_I,
  input  wire [`PIC_VOLT_W-1:0]    BANK_VOLTAGE_I,
  input  wire [`PIC_VOLT_W-1:0]    KEYSWITCH_SUPPLY_I,
  input  wire [`PIC_VOLT_W-1:0]    PRE_WINDOW_I,
  input  wire                      ENERGY_OVER_I,
  input  wire [`PIC_THR_W-1:0]     THROTTLE_IN_I,
  output wire                      CMD_DONE_O,
  output reg                       CMD_STATUS_O,
  output reg                       INVALID_SELECTOR_ERROR_O,
  output reg                       PRECHARGE_REQUEST_O,
  output reg  [`PIC_PST_W-1:0]     PRECHARGE_STATUS_O,
  output reg                       PRECHARGE_FAULT_O,
  output reg                       LOW_SIDE_OUTPUT_A_N_O,
  output reg                       LOW_SIDE_OUTPUT_A_OE_O,
  output reg                       LOW_SIDE_OUTPUT_B_N_O,
  output reg                       LOW_SIDE_OUTPUT_B_OE_O,
  output reg                       REVERSE_STATE_FLAG_O,
  output reg                       REVERSE_ACTIVE_O,
  output reg                       STARTUP_CHECK_REQ_O,
  output reg                       INTERLOCK_FLAG_O,
  output reg  [`PIC_THR_W-1:0]     THROTTLE_OUT_O,
  output reg                       CONTACTOR_CLOSE_REQ_O,
  output reg                       CONTACTOR_OPEN_REQ_O,
  output reg  [`PIC_POT_W-1:0]     POT_WIRING_TYPE_O
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg                    energy_s1_q;
  reg                    energy_s2_q;
  reg                    chk_s1_q;
  reg                    chk_s2_q;
  reg [`PIC_VOLT_W-1:0]  bank_s1_q;
  reg [`PIC_VOLT_W-1:0]  bank_s2_q;

  // bank voltage is a converter word; it is assumed to change slowly relative to the clock
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      energy_s1_q <= 1'b0;
      energy_s2_q <= 1'b0;
      chk_s1_q    <= 1'b0;
      chk_s2_q    <= 1'b0;
      bank_s1_q   <= {`PIC_VOLT_W{1'b0}};
      bank_s2_q   <= {`PIC_VOLT_W{1'b0}};
    end else begin
      energy_s1_q <= ENERGY_OVER_I;
      energy_s2_q <= energy_s1_q;
      chk_s1_q    <= STARTUP_CHECK_DONE_I;
      chk_s2_q    <= chk_s1_q;
      bank_s1_q   <= BANK_VOLTAGE_I;
      bank_s2_q   <= bank_s1_q;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  function is_cmd;
    input [`PIC_CMD_W-1:0] code;
    input [`PIC_CMD_W-1:0] want;
    begin
      is_cmd = CMD_VALID_I && (code == want);
    end
  endfunction

  function pot_type_ok;
    input [`PIC_SEL_W-1:0] arg;
    begin
      pot_type_ok = (arg == {6'h00, `PIC_POT_ONE_WIRE}) ||
                    (arg == {6'h00, `PIC_POT_TWO_WIRE}) ||
                    (arg == {6'h00, `PIC_POT_THREE_WIRE});
    end
  endfunction

  wire c_pre_on  = is_cmd(CMD_CODE_I, `PIC_CMD_PRE_ON);
  wire c_pre_off = is_cmd(CMD_CODE_I, `PIC_CMD_PRE_OFF);
  wire c_out_set = is_cmd(CMD_CODE_I, `PIC_CMD_OUT_SET);
  wire c_out_clr = is_cmd(CMD_CODE_I, `PIC_CMD_OUT_CLR);
  wire c_rev_on  = is_cmd(CMD_CODE_I, `PIC_CMD_REV_ON);
  wire c_rev_off = is_cmd(CMD_CODE_I, `PIC_CMD_REV_OFF);
  wire c_ilk_set = is_cmd(CMD_CODE_I, `PIC_CMD_ILK_SET);
  wire c_ilk_clr = is_cmd(CMD_CODE_I, `PIC_CMD_ILK_CLR);
  wire c_pot     = is_cmd(CMD_CODE_I, `PIC_CMD_POT_TYPE);

  wire sel_a     = (CMD_ARG_I == `PIC_SEL_OUT_A);
  wire sel_b     = (CMD_ARG_I == `PIC_SEL_OUT_B);
  wire sel_ok    = sel_a || sel_b;
  wire rev_soft  = (REVERSE_CONTROL_SELECT_I == `PIC_CTL_SOFT);
  wire ilk_soft  = (INTERLOCK_CONTROL_SELECT_I == `PIC_CTL_SOFT);

  // ****************************************
  // precharge sequencer
  // ****************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_END  = 3'b100;

  reg [2:0]             state_q;
  reg [2:0]             state_d;
  reg [`PIC_TMR_W-1:0]  tmr_q;
  reg [`PIC_TMR_W-1:0]  tmr_d;
  reg [`PIC_PST_W-1:0]  pst_d;
  reg                   fault_d;
  reg                   req_d;

  wire [`PIC_VOLT_W:0]  v_lo = {1'b0, KEYSWITCH_SUPPLY_I} - {1'b0, PRE_WINDOW_I};
  wire                  v_in_range = v_lo[`PIC_VOLT_W] ||
                                     ({1'b0, bank_s2_q} >= v_lo);
  wire                  tmr_out = (tmr_q >= PRE_TIMEOUT_CYC[`PIC_TMR_W-1:0] - 1'b1);

  always @* begin
    state_d = state_q;
    tmr_d   = tmr_q;
    pst_d   = PRECHARGE_STATUS_O;
    fault_d = PRECHARGE_FAULT_O;
    req_d   = PRECHARGE_REQUEST_O;
    if (c_pre_off) begin
      state_d = ST_IDLE;
      req_d   = 1'b0;
      fault_d = 1'b0;
      pst_d   = `PIC_PST_ABORT;
    end else if (c_pre_on) begin
      state_d = ST_RUN;
      tmr_d   = {`PIC_TMR_W{1'b0}};
      req_d   = 1'b1;
      fault_d = 1'b0;
      pst_d   = `PIC_PST_BUSY;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_RUN: begin
          tmr_d = tmr_q + 1'b1;
          // energy is checked first: it protects hardware, so it outranks a late pass
          if (energy_s2_q) begin
            state_d = ST_END;
            req_d   = 1'b0;
            fault_d = 1'b1;
            pst_d   = `PIC_PST_ENERGY;
          end else if (v_in_range) begin
            state_d = ST_END;
            req_d   = 1'b0;
            pst_d   = `PIC_PST_PASS;
          end else if (tmr_out) begin
            state_d = ST_END;
            req_d   = 1'b0;
            fault_d = 1'b1;
            pst_d   = `PIC_PST_TIMEOUT;
          end
        end
        ST_END: begin
          state_d = ST_END;
        end
        default: begin
          state_d = ST_IDLE;
          req_d   = 1'b0;
        end
      endcase
    end
  end

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q             <= ST_IDLE;
      tmr_q               <= {`PIC_TMR_W{1'b0}};
      PRECHARGE_STATUS_O  <= `PIC_PST_NONE;
      PRECHARGE_FAULT_O   <= 1'b0;
      PRECHARGE_REQUEST_O <= 1'b0;
    end else begin
      state_q             <= state_d;
      tmr_q               <= tmr_d;
      PRECHARGE_STATUS_O  <= pst_d;
      PRECHARGE_FAULT_O   <= fault_d;
      PRECHARGE_REQUEST_O <= req_d;
    end
  end

  // ****************************************
  // low-side outputs, reverse, interlock
  // ****************************************
  reg out_a_q;
  reg out_b_q;
  reg rev_q;
  reg ilk_q;

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      rev_q   <= 1'b0;
      ilk_q   <= 1'b0;
    end else begin
      if ((c_out_set || c_out_clr) && sel_a) begin
        out_a_q <= c_out_set;
      end
      if ((c_out_set || c_out_clr) && sel_b) begin
        out_b_q <= c_out_set;
      end
      if ((c_rev_on || c_rev_off) && rev_soft) begin
        rev_q <= c_rev_on;
      end
      if ((c_ilk_set || c_ilk_clr) && ilk_soft) begin
        ilk_q <= c_ilk_set;
      end
    end
  end

  // on means the driver sinks the pin; off releases it rather than driving high
  always @* begin
    LOW_SIDE_OUTPUT_A_N_O  = 1'b0;
    LOW_SIDE_OUTPUT_A_OE_O = out_a_q;
    LOW_SIDE_OUTPUT_B_N_O  = 1'b0;
    LOW_SIDE_OUTPUT_B_OE_O = out_b_q;
    REVERSE_STATE_FLAG_O   = rev_q;
    INTERLOCK_FLAG_O       = ilk_q;
  end

  // ****************************************
  // reverse exit and startup check
  // ****************************************
  reg chk_pend_q;
  reg rev_act_q;

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      chk_pend_q <= 1'b0;
      rev_act_q  <= 1'b0;
    end else begin
      if (rev_q) begin
        rev_act_q  <= 1'b1;
        chk_pend_q <= 1'b0;
      end else if (rev_act_q) begin
        rev_act_q  <= 1'b0;
        chk_pend_q <= STARTUP_SEQUENCE_CHECK_EN_I;
      end else if (chk_pend_q && chk_s2_q) begin
        chk_pend_q <= 1'b0;
      end
    end
  end

  // startup check request is raised while the check is outstanding and reverse is off
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REVERSE_ACTIVE_O    <= 1'b0;
      STARTUP_CHECK_REQ_O <= 1'b0;
    end else begin
      REVERSE_ACTIVE_O    <= rev_q;
      STARTUP_CHECK_REQ_O <= chk_pend_q && !rev_q;
    end
  end

  // ****************************************
  // throttle gate and contactor requests
  // ****************************************
  wire ilk_take_set = c_ilk_set && ilk_soft;
  wire ilk_take_clr = c_ilk_clr && ilk_soft;

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      THROTTLE_OUT_O        <= `PIC_THR_ZERO;
      CONTACTOR_CLOSE_REQ_O <= 1'b0;
      CONTACTOR_OPEN_REQ_O  <= 1'b0;
      POT_WIRING_TYPE_O     <= `PIC_POT_ONE_WIRE;
    end else begin
      THROTTLE_OUT_O        <= ilk_q ? THROTTLE_IN_I : `PIC_THR_ZERO;
      CONTACTOR_CLOSE_REQ_O <= ilk_take_set && MAIN_CONTACTOR_ENABLE_I;
      CONTACTOR_OPEN_REQ_O  <= ilk_take_clr && MAIN_CONTACTOR_ENABLE_I;
      if (c_pot && pot_type_ok(CMD_ARG_I)) begin
        POT_WIRING_TYPE_O <= CMD_ARG_I[`PIC_POT_W-1:0];
      end
    end
  end

  // ****************************************
  // command answer
  // ****************************************
  reg done_q;
  reg ok_d;

  always @* begin
    ok_d = 1'b0;
    if (c_pre_on || c_pre_off) begin
      ok_d = 1'b1;
    end else if (c_out_set || c_out_clr) begin
      ok_d = sel_ok;
    end else if (c_rev_on || c_rev_off) begin
      ok_d = rev_soft;
    end else if (c_ilk_set || c_ilk_clr) begin
      ok_d = ilk_soft;
    end else if (c_pot) begin
      ok_d = pot_type_ok(CMD_ARG_I);
    end
  end

  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      done_q                   <= 1'b0;
      CMD_STATUS_O             <= 1'b0;
      INVALID_SELECTOR_ERROR_O <= 1'b0;
    end else begin
      done_q                   <= CMD_VALID_I;
      if (CMD_VALID_I) begin
        CMD_STATUS_O             <= ok_d;
        INVALID_SELECTOR_ERROR_O <= (c_out_set || c_out_clr) && !sel_ok;
      end
    end
  end

  assign CMD_DONE_O = done_q;

endmodule

/* File: verification/pic_precharge_interlock_properties.sv */
`timescale 1ns/100ps
`include "pic_defines.vh"

// ****************************************
// port checker
// ****************************************
module pic_precharge_interlock_properties #(
  parameter int PRE_TIMEOUT_CYC = 50
) (
  input wire                   MCLK_I,
  input wire                   RST_N_I,
  input wire                   CMD_VALID_I,
  input wire [`PIC_CMD_W-1:0]  CMD_CODE_I,
  input wire [`PIC_SEL_W-1:0]  CMD_ARG_I,
  input wire [`PIC_CTL_W-1:0]  REVERSE_CONTROL_SELECT_I,
  input wire [`PIC_CTL_W-1:0]  INTERLOCK_CONTROL_SELECT_I,
  input wire                   MAIN_CONTACTOR_ENABLE_I,
  input wire [`PIC_THR_W-1:0]  THROTTLE_IN_I,
  input wire                   CMD_DONE_O,
  input wire                   CMD_STATUS_O,
  input wire                   INVALID_SELECTOR_ERROR_O,
  input wire                   PRECHARGE_REQUEST_O,
  input wire [`PIC_PST_W-1:0]  PRECHARGE_STATUS_O,
  input wire                   PRECHARGE_FAULT_O,
  input wire                   LOW_SIDE_OUTPUT_A_N_O,
  input wire                   LOW_SIDE_OUTPUT_A_OE_O,
  input wire                   LOW_SIDE_OUTPUT_B_N_O,
  input wire                   LOW_SIDE_OUTPUT_B_OE_O,
  input wire                   REVERSE_STATE_FLAG_O,
  input wire                   REVERSE_ACTIVE_O,
  input wire                   INTERLOCK_FLAG_O,
  input wire [`PIC_THR_W-1:0]  THROTTLE_OUT_O,
  input wire                   CONTACTOR_CLOSE_REQ_O,
  input wire                   CONTACTOR_OPEN_REQ_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // counts how long one request has been standing
  reg  [`PIC_TMR_W-1:0] run_q;
  wire                  c_on = CMD_VALID_I && CMD_CODE_I == `PIC_CMD_PRE_ON;
  wire                  c_off = CMD_VALID_I && CMD_CODE_I == `PIC_CMD_PRE_OFF;
  wire                  c_out = CMD_VALID_I && (CMD_CODE_I == `PIC_CMD_OUT_SET || CMD_CODE_I == `PIC_CMD_OUT_CLR);
  wire                  bad_sel = CMD_ARG_I != `PIC_SEL_OUT_A && CMD_ARG_I != `PIC_SEL_OUT_B;
  wire                  c_rev = CMD_VALID_I && (CMD_CODE_I == `PIC_CMD_REV_ON || CMD_CODE_I == `PIC_CMD_REV_OFF);
  wire                  c_ilk = CMD_VALID_I && (CMD_CODE_I == `PIC_CMD_ILK_SET || CMD_CODE_I == `PIC_CMD_ILK_CLR);
  wire                  ilk_ok = INTERLOCK_CONTROL_SELECT_I == `PIC_CTL_SOFT && MAIN_CONTACTOR_ENABLE_I;
  always @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) run_q <= 'h0;
    else run_q <= PRECHARGE_REQUEST_O ? run_q + 1'b1 : 'h0;
  end

  AST_DONE_PULSE: assert property (CMD_DONE_O == $past(CMD_VALID_I)) else $error("done pulse off");
  AST_PIN_LOW: assert property (!LOW_SIDE_OUTPUT_A_N_O && !LOW_SIDE_OUTPUT_B_N_O) else $error("pin drive");
  AST_BAD_SEL: assert property (c_out && bad_sel |=> INVALID_SELECTOR_ERROR_O && !CMD_STATUS_O
    && $stable(LOW_SIDE_OUTPUT_A_OE_O) && $stable(LOW_SIDE_OUTPUT_B_OE_O)) else $error("bad selector acted");
  AST_REV_GATE: assert property (c_rev && REVERSE_CONTROL_SELECT_I != `PIC_CTL_SOFT
    |=> !CMD_STATUS_O && $stable(REVERSE_STATE_FLAG_O)) else $error("reverse gate");
  AST_ILK_GATE: assert property (c_ilk && INTERLOCK_CONTROL_SELECT_I != `PIC_CTL_SOFT
    |=> !CMD_STATUS_O && $stable(INTERLOCK_FLAG_O)) else $error("interlock gate");
  AST_THR_PASS: assert property (INTERLOCK_FLAG_O |=> THROTTLE_OUT_O == $past(THROTTLE_IN_I)) else $error("thr");
  AST_THR_BLOCK: assert property (!INTERLOCK_FLAG_O |=> THROTTLE_OUT_O == `PIC_THR_ZERO) else $error("thr");
  AST_CLOSE: assert property (c_ilk && CMD_CODE_I == `PIC_CMD_ILK_SET && ilk_ok
    |=> CONTACTOR_CLOSE_REQ_O && INTERLOCK_FLAG_O
    ##1 (!CONTACTOR_CLOSE_REQ_O || $past(c_ilk && CMD_CODE_I == `PIC_CMD_ILK_SET && ilk_ok)))
    else $error("close req");
  AST_OPEN: assert property (c_ilk && CMD_CODE_I == `PIC_CMD_ILK_CLR && ilk_ok
    |=> CONTACTOR_OPEN_REQ_O && !INTERLOCK_FLAG_O
    ##1 (!CONTACTOR_OPEN_REQ_O || $past(c_ilk && CMD_CODE_I == `PIC_CMD_ILK_CLR && ilk_ok)))
    else $error("open req");
  AST_PRE_START: assert property (c_on |=> PRECHARGE_REQUEST_O && PRECHARGE_STATUS_O == `PIC_PST_BUSY)
    else $error("precharge start");
  AST_ABORT: assert property (c_off |=> !PRECHARGE_REQUEST_O && !PRECHARGE_FAULT_O
    && PRECHARGE_STATUS_O == `PIC_PST_ABORT) else $error("abort");
  AST_PRE_END: assert property ($fell(PRECHARGE_REQUEST_O) |-> PRECHARGE_STATUS_O >= `PIC_PST_PASS)
    else $error("precharge end code");
  AST_PST_HOLD: assert property (!$stable(PRECHARGE_STATUS_O) |-> $past(CMD_VALID_I)
    || $past(PRECHARGE_REQUEST_O)) else $error("status moved");
  AST_PRE_LIMIT: assert property (run_q <= PRE_TIMEOUT_CYC + 3) else $error("precharge ran too long");
  AST_REV_END: assert property ($fell(REVERSE_STATE_FLAG_O) |=> !REVERSE_ACTIVE_O) else $error("reverse end");

  COV_TIMEOUT: cover property (PRECHARGE_STATUS_O == `PIC_PST_TIMEOUT);
  COV_PASS: cover property (PRECHARGE_STATUS_O == `PIC_PST_PASS);
  COV_CLOSE: cover property (CONTACTOR_CLOSE_REQ_O);
endmodule

bind pic_precharge_interlock pic_precharge_interlock_properties #(.PRE_TIMEOUT_CYC(PRE_TIMEOUT_CYC)) chk_u (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I), .CMD_ARG_I(CMD_ARG_I),
  .REVERSE_CONTROL_SELECT_I(REVERSE_CONTROL_SELECT_I), .INTERLOCK_CONTROL_SELECT_I(INTERLOCK_CONTROL_SELECT_I),
  .MAIN_CONTACTOR_ENABLE_I(MAIN_CONTACTOR_ENABLE_I), .THROTTLE_IN_I(THROTTLE_IN_I), .CMD_DONE_O(CMD_DONE_O),
  .CMD_STATUS_O(CMD_STATUS_O), .INVALID_SELECTOR_ERROR_O(INVALID_SELECTOR_ERROR_O),
  .PRECHARGE_REQUEST_O(PRECHARGE_REQUEST_O), .PRECHARGE_STATUS_O(PRECHARGE_STATUS_O),
  .PRECHARGE_FAULT_O(PRECHARGE_FAULT_O), .LOW_SIDE_OUTPUT_A_N_O(LOW_SIDE_OUTPUT_A_N_O),
  .LOW_SIDE_OUTPUT_A_OE_O(LOW_SIDE_OUTPUT_A_OE_O), .LOW_SIDE_OUTPUT_B_N_O(LOW_SIDE_OUTPUT_B_N_O),
  .LOW_SIDE_OUTPUT_B_OE_O(LOW_SIDE_OUTPUT_B_OE_O), .REVERSE_STATE_FLAG_O(REVERSE_STATE_FLAG_O),
  .REVERSE_ACTIVE_O(REVERSE_ACTIVE_O), .INTERLOCK_FLAG_O(INTERLOCK_FLAG_O), .THROTTLE_OUT_O(THROTTLE_OUT_O),
  .CONTACTOR_CLOSE_REQ_O(CONTACTOR_CLOSE_REQ_O), .CONTACTOR_OPEN_REQ_O(CONTACTOR_OPEN_REQ_O)
);

/* File: verification/pic_precharge_interlock_bench.sv */
`timescale 1ns/100ps
`include "pic_defines.vh"

module pic_precharge_interlock_bench;
  // ****************************************
  // stimulus and design
  // ****************************************
  reg         clk, rst_n, valid, mce, cken, cdone, energy;
  reg  [3:0]  code, rsel, isel;
  reg  [7:0]  arg;
  reg  [11:0] bank, ksup, win;
  reg  [15:0] thr;
  wire        done, st, err, preq, pfault, na, oea, nb, oeb, rflag, ract, sreq, ilk, creq, oreq;
  wire [2:0]  pst;
  wire [15:0] thro;
  wire [1:0]  pot;
  integer     fails, total_checks, i, j;
  reg         ea, eb, ok;

  // short timeout keeps the run small
  pic_precharge_interlock #(.PRE_TIMEOUT_CYC(50)) dut_u (
    .MCLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_CODE_I(code), .CMD_ARG_I(arg),
    .REVERSE_CONTROL_SELECT_I(rsel), .INTERLOCK_CONTROL_SELECT_I(isel), .MAIN_CONTACTOR_ENABLE_I(mce),
    .STARTUP_SEQUENCE_CHECK_EN_I(cken), .STARTUP_CHECK_DONE_I(cdone), .BANK_VOLTAGE_I(bank),
    .KEYSWITCH_SUPPLY_I(ksup), .PRE_WINDOW_I(win), .ENERGY_OVER_I(energy), .THROTTLE_IN_I(thr),
    .CMD_DONE_O(done), .CMD_STATUS_O(st), .INVALID_SELECTOR_ERROR_O(err), .PRECHARGE_REQUEST_O(preq),
    .PRECHARGE_STATUS_O(pst), .PRECHARGE_FAULT_O(pfault), .LOW_SIDE_OUTPUT_A_N_O(na),
    .LOW_SIDE_OUTPUT_A_OE_O(oea), .LOW_SIDE_OUTPUT_B_N_O(nb), .LOW_SIDE_OUTPUT_B_OE_O(oeb),
    .REVERSE_STATE_FLAG_O(rflag), .REVERSE_ACTIVE_O(ract), .STARTUP_CHECK_REQ_O(sreq),
    .INTERLOCK_FLAG_O(ilk), .THROTTLE_OUT_O(thro), .CONTACTOR_CLOSE_REQ_O(creq),
    .CONTACTOR_OPEN_REQ_O(oreq), .POT_WIRING_TYPE_O(pot)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // access tasks
  // ****************************************
  // wide enough for the longest packed compare, so no flag bit is cut off
  task chk(input [19:0] got, input [19:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask

  task cmd(input [3:0] c, input [7:0] a);
    begin
      @(posedge clk);
      valid <= 1'b1;
      code <= c;
      arg <= a;
      @(posedge clk);
      valid <= 1'b0;
      #1;
      chk(done, 1'b1);
    end
  endtask

  // bounded wait for a precharge outcome
  task wait_pst(input [2:0] e);
    integer n;
    begin
      n = 0;
      while (pst !== e && n < 100) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(pst, e);
    end
  endtask

  task close_out;
    begin
      if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    fails = 0; total_checks = 0; rst_n = 1'b0; valid = 1'b0; code = 4'h0; arg = 8'h00;
    rsel = 4'h0; isel = 4'h0; mce = 1'b1; cken = 1'b0; cdone = 1'b0; energy = 1'b0;
    bank = 12'h000; ksup = 12'h064; win = 12'h00A; thr = 16'h1234; ea = 1'b0; eb = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(pst, `PIC_PST_NONE);
    chk({oeb, oea}, 2'h0);
    chk({rflag, ilk}, 2'h0);
    chk(pot, `PIC_POT_ONE_WIRE);
    for (j = 0; j < 2; j = j + 1) begin
      for (i = 5; i <= 8; i = i + 1) begin
        cmd(j ? `PIC_CMD_OUT_CLR : `PIC_CMD_OUT_SET, i[7:0]);
        ok = (i == 6 || i == 7);
        if (i == 6) ea = !j;
        if (i == 7) eb = !j;
        chk({err, st}, {!ok, ok});
        chk({oeb, oea}, {eb, ea});
        chk({nb, na}, 2'h0);
      end
    end
    cmd(`PIC_CMD_PRE_ON, 8'h00);
    chk({preq, pst}, {1'b1, `PIC_PST_BUSY});
    wait_pst(`PIC_PST_TIMEOUT);
    chk({preq, pfault}, 2'h1);
    cmd(`PIC_CMD_PRE_OFF, 8'h00);
    chk({preq, pfault, pst}, {2'h0, `PIC_PST_ABORT});
    cmd(`PIC_CMD_PRE_ON, 8'h00);
    @(posedge clk);
    energy <= 1'b1;
    wait_pst(`PIC_PST_ENERGY);
    chk({preq, pfault}, 2'h1);
    energy <= 1'b0;
    cmd(`PIC_CMD_PRE_ON, 8'h00);
    chk(pfault, 1'b0);
    bank <= 12'h05A;
    wait_pst(`PIC_PST_PASS);
    repeat (5) @(posedge clk);
    #1;
    chk({preq, pst}, {1'b0, `PIC_PST_PASS});
    cmd(`PIC_CMD_REV_ON, 8'h00);
    chk({st, rflag}, 2'h0);
    rsel <= `PIC_CTL_SOFT;
    cken <= 1'b1;
    cmd(`PIC_CMD_REV_ON, 8'h00);
    chk({st, rflag}, 2'h3);
    cmd(`PIC_CMD_REV_OFF, 8'h00);
    chk({st, rflag}, 2'h2);
    repeat (2) @(posedge clk);
    #1;
    chk({ract, sreq}, 2'h1);
    cdone <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(sreq, 1'b0);
    cdone <= 1'b0;
    cken <= 1'b0;
    cmd(`PIC_CMD_REV_ON, 8'h00);
    cmd(`PIC_CMD_REV_OFF, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({ract, sreq}, 2'h0);
    cmd(`PIC_CMD_ILK_SET, 8'h00);
    chk({st, ilk, creq, thro}, 19'h0);
    isel <= `PIC_CTL_SOFT;
    cmd(`PIC_CMD_ILK_SET, 8'h00);
    chk({st, ilk, creq}, 3'h7);
    @(posedge clk);
    #1;
    chk(thro, 16'h1234);
    cmd(`PIC_CMD_ILK_CLR, 8'h00);
    chk({st, ilk, oreq}, 3'h5);
    @(posedge clk);
    #1;
    chk(thro, `PIC_THR_ZERO);
    mce <= 1'b0;
    cmd(`PIC_CMD_ILK_SET, 8'h00);
    chk({st, ilk, creq}, 3'h6);
    cmd(`PIC_CMD_ILK_CLR, 8'h00);
    chk({st, ilk, oreq}, 3'h4);
    for (i = 3; i >= 0; i = i - 1) begin
      cmd(`PIC_CMD_POT_TYPE, i[7:0]);
      // a refused type keeps the one-wire selection left by the previous call
      chk({st, pot}, {i != 0, (i == 0) ? `PIC_POT_ONE_WIRE : i[1:0]});
    end
    cmd(4'hF, 8'h00);
    chk(st, 1'b0);
    close_out;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    close_out;
  end
endmodule
